// ---- src/vc0_ctrl_consts.vh ----
/*
  constants for the channel zero control register: offset, reset word,
  field positions and fixed field values.
  assumes inclusion by bare name from the design files.
*/
`ifndef VC0_CTRL_CONSTS_VH
`define VC0_CTRL_CONSTS_VH

// register placement and reset word
`define VC0_CTRL_OFFSET      12'h164
`define VC0_CTRL_RESET       32'h800000ff
`define CFG_ADDR_W           12
`define CFG_DATA_W           32
`define CFG_BE_W             4
`define WORD_ALIGN_ZERO      2'b00

// field positions
`define ACTIVE_BIT           31
`define RSVD_HI_MSB          30
`define RSVD_HI_LSB          27
`define CHAN_NUM_MSB         26
`define CHAN_NUM_LSB         24
`define RSVD_MID_MSB         23
`define RSVD_MID_LSB         20
`define ARB_SEL_MSB          19
`define ARB_SEL_LSB          17
`define TABLE_LOAD_BIT       16
`define RSVD_LO_MSB          15
`define RSVD_LO_LSB          8
`define MAP_MSB              7
`define MAP_LSB              0
`define MAP_RW_LSB           1
`define MAP_LANE             0

// fixed field values
`define ACTIVE_VAL           1'b1
`define RSVD_HI_VAL          4'h0
`define CHAN_NUM_VAL         3'h0
`define RSVD_MID_VAL         4'h0
`define ARB_SEL_VAL          3'h0
`define TABLE_LOAD_VAL       1'b0
`define RSVD_LO_VAL          8'h00
`define MAP_CLASS0_VAL       1'b1
`define MAP_RW_RESET         7'h7f
`define MAP_RESET            8'hff
`define DATA_ZERO            32'h00000000

`endif

// ---- src/class_lookup.v ----
/*
  traffic class lookup: tells whether a class index is mapped to channel zero.
  assumes a map vector from the control register, same clock domain.
*/
`timescale 1ns/1ps
module class_lookup #(
  parameter CLASSES = 8,
  parameter IDX_W   = 3
) (
  input  wire [CLASSES-1:0] map_i,
  input  wire [IDX_W-1:0]   idx_i,
  output wire               hit_o
);

  // set bit carries the class on channel zero, clear bit sends it elsewhere
  assign hit_o = map_i[idx_i];

endmodule

// ---- src/vc0_resource_control_reg.v ----
/*
  channel zero resource control register of the extended configuration space:
  stored map bits, fixed read-only fields, access decode, access answer,
  map change pulse and a class lookup port for the arbitration datapath.
  assumes the configuration logic runs on the system clock, so every input is
  in the CLK_SYS_I domain and none passes a synchroniser.
  assumes each access is a single-cycle read or write strobe, with address,
  byte enables and write data valid in the strobe cycle.
  assumes the answer is taken one cycle after the strobe: ack pulses for
  every access, hit only for the register's dword.
  assumes read data holds until the next read strobe is taken.
  assumes a read and a write in one cycle read the value before the write.
  assumes an unmapped address answers zero data and ignores writes.
  assumes only byte lane 0 carries writable bits; other lanes are dropped.
  assumes lookup queries are single-cycle strobes answered one cycle later,
  the answer holding until the next query.
*/
// Summary of operation
// - 32-bit register at extended offset 164h, reset value 8000 00FFh.
// - bit 31 channel active flag always reads one.
// - reserved bits 30:27 and 23:20 always read zero.
// - channel number bits 26:24 are fixed at zero.
// - arbiter choice bits 19:17 read zero, round-robin only.
// - table load bit 16 is read-only and reads zero.
// - reserved bits 15:8 always read zero.
// - map bits 7:1 are writable; a set bit carries that class on channel zero.
// - a clear map bit sends that class to another channel.
// - map bit n stands for traffic class n, for n from 1 to 7.
// - map bit 0 is read-only and always reads one.
// - after reset the map is FFh.
`timescale 1ns/1ps
`include "vc0_ctrl_consts.vh"
module vc0_resource_control_reg #(
  parameter CLASSES = 8,
  parameter IDX_W   = 3
) (
  input  wire                   CLK_SYS_I,
  input  wire                   RST_N_I,
  input  wire [`CFG_ADDR_W-1:0] CFG_ADDR_I,
  input  wire                   CFG_WR_I,
  input  wire                   CFG_RD_I,
  input  wire [`CFG_BE_W-1:0]   CFG_BE_I,
  input  wire [`CFG_DATA_W-1:0] CFG_WDATA_I,
  output reg  [`CFG_DATA_W-1:0] CFG_RDATA_O,
  output reg                    CFG_ACK_O,
  output reg                    CFG_HIT_O,
  output reg  [CLASSES-1:0]     CLASS_MAP_O,
  output wire                   CHANNEL_ACTIVE_O,
  output reg                    MAP_CHANGED_O,
  input  wire                   TC_QUERY_VALID_I,
  input  wire [IDX_W-1:0]       TC_QUERY_I,
  output reg                    TC_QUERY_DONE_O,
  output reg                    TC_ON_CH0_O
);

  // writable part of the map, bits 7:1
  reg  [`MAP_MSB:`MAP_RW_LSB]           map_rw;
  wire [`MAP_MSB:`MAP_RW_LSB]           next_map_rw;
  wire [`MAP_MSB:`MAP_RW_LSB]           map_bit_diff;

  // access decode
  reg                                   addr_hit;
  reg                                   wr_take;
  reg                                   rd_take;
  reg                                   access;
  reg                                   lane_wr;

  // readback fields
  wire                                  active_field;
  wire [`RSVD_HI_MSB-`RSVD_HI_LSB:0]    rsvd_hi_field;
  wire [`CHAN_NUM_MSB-`CHAN_NUM_LSB:0]  chan_num_field;
  wire [`RSVD_MID_MSB-`RSVD_MID_LSB:0]  rsvd_mid_field;
  wire [`ARB_SEL_MSB-`ARB_SEL_LSB:0]    arb_sel_field;
  wire                                  table_load_field;
  wire [`RSVD_LO_MSB-`RSVD_LO_LSB:0]    rsvd_lo_field;
  wire [CLASSES-1:0]                    map_full;
  reg  [`CFG_DATA_W-1:0]                reg_word;
  wire                                  lookup_hit;

  // next values
  reg  [`CFG_DATA_W-1:0]                next_rdata;
  reg                                   next_ack;
  reg                                   next_hit;
  wire                                  next_changed;
  wire [CLASSES-1:0]                    next_class_map;
  reg                                   next_query_done;
  reg                                   next_on_ch0;

  // dword-aligned decode of the single register, bits 1:0 ignored
  always @* begin
    addr_hit = 1'b0;
    if ({CFG_ADDR_I[`CFG_ADDR_W-1:2], `WORD_ALIGN_ZERO} == `VC0_CTRL_OFFSET) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // strobe qualification; only byte lane 0 holds writable bits
  always @* begin
    wr_take = CFG_WR_I & addr_hit;
    rd_take = CFG_RD_I;
    access  = CFG_WR_I | CFG_RD_I;
    lane_wr = 1'b0;
    if (wr_take) begin
      if (CFG_BE_I[`MAP_LANE]) begin
        lane_wr = 1'b1;
      end
    end
  end

  // fixed fields are constants, never stored
  assign active_field     = `ACTIVE_VAL;
  assign rsvd_hi_field    = `RSVD_HI_VAL;
  assign chan_num_field   = `CHAN_NUM_VAL;
  assign rsvd_mid_field   = `RSVD_MID_VAL;
  assign arb_sel_field    = `ARB_SEL_VAL;
  assign table_load_field = `TABLE_LOAD_VAL;
  assign rsvd_lo_field    = `RSVD_LO_VAL;

  // class 0 is held on channel zero regardless of writes
  assign map_full = {map_rw, `MAP_CLASS0_VAL};

  assign CHANNEL_ACTIVE_O = active_field;

  // read word assembly, field by field
  always @* begin
    reg_word                              = `DATA_ZERO;
    reg_word[`ACTIVE_BIT]                 = active_field;
    reg_word[`RSVD_HI_MSB:`RSVD_HI_LSB]   = rsvd_hi_field;
    reg_word[`CHAN_NUM_MSB:`CHAN_NUM_LSB] = chan_num_field;
    reg_word[`RSVD_MID_MSB:`RSVD_MID_LSB] = rsvd_mid_field;
    reg_word[`ARB_SEL_MSB:`ARB_SEL_LSB]   = arb_sel_field;
    reg_word[`TABLE_LOAD_BIT]             = table_load_field;
    reg_word[`RSVD_LO_MSB:`RSVD_LO_LSB]   = rsvd_lo_field;
    reg_word[`MAP_MSB:`MAP_LSB]           = map_full;
  end

  // write path: each writable map bit takes lane 0 data on a qualified write
  genvar k;
  generate
    for (k = `MAP_RW_LSB; k <= `MAP_MSB; k = k + 1) begin : g_map_bit
      assign next_map_rw[k]  = lane_wr ? CFG_WDATA_I[k] : map_rw[k];
      assign map_bit_diff[k] = next_map_rw[k] ^ map_rw[k];
    end
  endgenerate

  // a write that flips any writable bit raises the change pulse
  assign next_changed   = |map_bit_diff;
  assign next_class_map = {next_map_rw, `MAP_CLASS0_VAL};

  // read path: a hit returns the word, any other address returns zero
  always @* begin
    next_rdata = CFG_RDATA_O;
    if (rd_take) begin
      if (addr_hit) begin
        next_rdata = reg_word;
      end else begin
        next_rdata = `DATA_ZERO;
      end
    end
  end

  // access answer: ack for every strobe, hit only for this register
  always @* begin
    next_ack = 1'b0;
    next_hit = 1'b0;
    if (access) begin
      next_ack = 1'b1;
      next_hit = addr_hit;
    end
  end

  // stored map bits
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      map_rw <= `MAP_RW_RESET;
    end else begin
      map_rw <= next_map_rw;
    end
  end

  // registered copy of the whole map
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      CLASS_MAP_O <= `MAP_RESET;
    end else begin
      CLASS_MAP_O <= next_class_map;
    end
  end

  // read data holds until the next read strobe
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      CFG_RDATA_O <= `DATA_ZERO;
    end else begin
      CFG_RDATA_O <= next_rdata;
    end
  end

  // one-cycle access answer and change pulse
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      CFG_ACK_O     <= 1'b0;
      CFG_HIT_O     <= 1'b0;
      MAP_CHANGED_O <= 1'b0;
    end else begin
      CFG_ACK_O     <= next_ack;
      CFG_HIT_O     <= next_hit;
      MAP_CHANGED_O <= next_changed;
    end
  end

  // class lookup for the arbitration datapath
  class_lookup #(
    .CLASSES (CLASSES),
    .IDX_W   (IDX_W)
  ) u_class_lookup (
    .map_i   (map_full),
    .idx_i   (TC_QUERY_I),
    .hit_o   (lookup_hit)
  );

  // lookup answer: done pulses one cycle after a query, result holds
  always @* begin
    next_query_done = TC_QUERY_VALID_I;
    next_on_ch0     = TC_ON_CH0_O;
    if (TC_QUERY_VALID_I) begin
      next_on_ch0 = lookup_hit;
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      TC_QUERY_DONE_O <= 1'b0;
      TC_ON_CH0_O     <= 1'b0;
    end else begin
      TC_QUERY_DONE_O <= next_query_done;
      TC_ON_CH0_O     <= next_on_ch0;
    end
  end

endmodule

// ---- verif/vc0_ctrl_properties.sv ----
/* port checker for the channel zero control register.
   assumes binding onto the design top, one clock domain. */
`timescale 1ns/1ps
module vc0_ctrl_properties #(
  parameter CLASSES = 8,
  parameter IDX_W   = 3
) (
  input wire               CLK_SYS_I,
  input wire               RST_N_I,
  input wire [11:0]        CFG_ADDR_I,
  input wire               CFG_WR_I,
  input wire               CFG_RD_I,
  input wire [3:0]         CFG_BE_I,
  input wire [31:0]        CFG_WDATA_I,
  input wire [31:0]        CFG_RDATA_O,
  input wire               CFG_ACK_O,
  input wire               CFG_HIT_O,
  input wire [CLASSES-1:0] CLASS_MAP_O,
  input wire               TC_QUERY_VALID_I,
  input wire [IDX_W-1:0]   TC_QUERY_I,
  input wire               TC_QUERY_DONE_O,
  input wire               TC_ON_CH0_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  wire sel = CFG_ADDR_I[11:2] == 10'h059;
  wire wen = CFG_WR_I && sel && CFG_BE_I[0];
  chk_ack_pulse: assert property ((CFG_WR_I || CFG_RD_I) |=> CFG_ACK_O)
    else $error("ack missing");
  chk_ack_idle: assert property (!(CFG_WR_I || CFG_RD_I) |=> !CFG_ACK_O)
    else $error("ack without access");
  chk_hit_decode: assert property ((CFG_WR_I || CFG_RD_I) |=> CFG_HIT_O == $past(sel))
    else $error("hit wrong");
  chk_active_read: assert property (CFG_RD_I && sel |=> CFG_RDATA_O[31])
    else $error("active flag low");
  chk_fixed_zero: assert property (
    CFG_RD_I && sel |=> CFG_RDATA_O[30:8] == 23'h0) else $error("fixed bits set");
  chk_class0_set: assert property (CLASS_MAP_O[0])
    else $error("class 0 clear");
  chk_map_write: assert property (
    wen |=> CLASS_MAP_O[7:1] == $past(CFG_WDATA_I[7:1])) else $error("map not written");
  chk_map_hold: assert property (!wen |=> $stable(CLASS_MAP_O))
    else $error("map changed");
  chk_lookup_map: assert property (TC_QUERY_VALID_I |=> TC_QUERY_DONE_O &&
    TC_ON_CH0_O == |($past(CLASS_MAP_O) & (8'h01 << $past(TC_QUERY_I)))) else $error("lookup");
endmodule
bind vc0_resource_control_reg vc0_ctrl_properties #(.CLASSES(CLASSES), .IDX_W(IDX_W)) u_chk (.*);

// ---- verif/vc0_resource_control_reg_tb.sv ----
/* self-checking bench for the channel zero control register.
   assumes the design and checker files are compiled first. */
`timescale 1ns/1ps
`define CK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module vc0_resource_control_reg_tb;
  reg        clk = 0, rst_n = 0, wr = 0, rd = 0, qv = 0;
  reg [11:0] addr = 0;
  reg [3:0]  be = 0;
  reg [31:0] wdata = 0, d;
  reg [2:0]  tc = 0;
  reg [7:0]  m = 8'hff;
  wire [31:0] rdata;
  wire [7:0]  map;
  wire        ack, hit, act, chg, qd, on;
  int         n_fail = 0, checked = 0, i;
  always #5 clk = ~clk;
  vc0_resource_control_reg vc0_resource_control_reg_inst (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .CFG_ADDR_I(addr), .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_BE_I(be), .CFG_WDATA_I(wdata),
    .CFG_RDATA_O(rdata), .CFG_ACK_O(ack), .CFG_HIT_O(hit), .CLASS_MAP_O(map),
    .CHANNEL_ACTIVE_O(act), .MAP_CHANGED_O(chg), .TC_QUERY_VALID_I(qv), .TC_QUERY_I(tc),
    .TC_QUERY_DONE_O(qd), .TC_ON_CH0_O(on));
  task acc(input reg w, input reg r, input reg [11:0] a, input reg [31:0] x, input reg [3:0] b);
    reg h;
    reg [7:0] old;
    begin
      h = a[11:2] == 10'h059;
      old = m;
      @(negedge clk);
      wr = w;
      rd = r;
      addr = a;
      wdata = x;
      be = b;
      @(negedge clk);
      wr = 0;
      rd = 0;
      if (w && h && b[0]) m = {x[7:1], 1'b1};
      `CK(ack, w | r)
      `CK(hit, (w | r) & h)
      `CK(act, 1'b1)
      if (r) `CK(rdata, h ? {24'h800000, old} : 32'h0)
      `CK(map, m)
      `CK(chg, m != old)
    end
  endtask
  task q(input reg [2:0] c);
    begin
      @(negedge clk);
      qv = 1;
      tc = c;
      @(negedge clk);
      qv = 0;
      `CK(qd, 1'b1)
      `CK(on, m[c])
    end
  endtask
  task print_verdict;
    begin
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #20000 n_fail++;
    print_verdict;
  end
  initial begin
    void'($urandom(36543));
    repeat (3) @(negedge clk);
    rst_n = 1;
    `CK(map, 8'hff)
    acc(0, 1, 12'h164, 0, 4'h1);
    acc(1, 0, 12'h164, 32'hffffffff, 4'hf);
    acc(0, 1, 12'h164, 0, 4'h1);
    acc(1, 1, 12'h164, 0, 4'h1);
    acc(1, 0, 12'h164, 32'hff, 4'he);
    acc(0, 1, 12'h160, 0, 4'h1);
    for (i = 0; i < 8; i++) q(i);
    @(negedge clk);
    rst_n = 0;
    @(negedge clk);
    rst_n = 1;
    m = 8'hff;
    `CK(map, 8'hff)
    `CK(ack, 1'b0)
    acc(0, 1, 12'h164, 0, 4'h0);
    repeat (60) begin
      d = $urandom;
      acc(d[8], d[9], d[10] ? 12'h164 : d[23:12], $urandom, d[27:24]);
      q(d[30:28]);
    end
    print_verdict;
  end
endmodule
